// file: hdl/dp_lane_aux_snoop_ctrl.sv
// DP lane equalization, AUX snoop and AUX-to-SBU routing control.
// Assumes a synchronous byte register port and a decoded AUX request
// strobe carrying command, DPCD address and first data byte.
`timescale 1ns/1ps

// Functional notes
// - Lane 0 EQ upper nibble, pins when not overridden
// - Lane 2 EQ lower nibble, pins when not overridden
// - Override set: lane 0 EQ from register
// - Override set: lane 2 EQ from register
// - Capture AUX write at 0x00600 into power
// - Snoop on: power state gates DP lanes
// - Clear power field on enable falling edge
// - Capture AUX write at 0x00101 into count
// - Snoop on: enable counted lanes, others down
// - Clear count field on enable falling edge
// - Snoop off: lanes follow software disable bits
// - Snoop-disable bit 7, resets zero
// - Route field bits 5:4, 00 follows controls
// - Route 01: AUXn-SBU1, AUXp-SBU2 forced
// - Route 10: AUXn-SBU2, AUXp-SBU1 forced
// - Route 11: AUX open from SBU
// - Bits 3:0 lane disables, reset zero
// - Snoop on: disable bits stored, no effect
// - EQ source: zero pins, one registers
// - Lane config selects USB and DP lanes
module dp_lane_aux_snoop_ctrl
  import dp_lane_aux_snoop_pkg::*;
#(
  parameter int EQ_W = 4
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  output logic      [7:0]      reg_rdata,
  input  wire logic            eq_source_select,
  input  wire logic [EQ_W-1:0] dp_eq_strap_pins,
  input  wire logic            display_enable_ctrl,
  input  wire logic [1:0]      lane_config_select,
  input  wire logic            orientation_select,
  input  wire logic            aux_req_valid,
  input  wire logic [3:0]      aux_req_cmd,
  input  wire logic [19:0]     aux_req_addr,
  input  wire logic [7:0]      aux_req_data,
  output logic      [3:0]      dp_lane_en,
  output logic                 usb3_en,
  output logic      [EQ_W-1:0] lane0_eq_applied,
  output logic      [EQ_W-1:0] lane2_eq_applied,
  output logic                 auxn_sbu1,
  output logic                 auxp_sbu2,
  output logic                 auxn_sbu2,
  output logic                 auxp_sbu1
);

  typedef struct packed {
    logic [EQ_W-1:0] lane0_eq_level;
    logic [EQ_W-1:0] lane2_eq_level;
    logic [1:0]      power_state;
    logic [4:0]      lane_count;
    logic            snoop_off;
    logic [1:0]      sideband_route_override;
    logic [3:0]      per_lane_off_bits;
    logic            enable_d;
    logic [7:0]      rdata;
    logic [3:0]      lane_en;
    logic            usb_en;
    logic [EQ_W-1:0] eq0;
    logic [EQ_W-1:0] eq2;
    logic [3:0]      sbu;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Switch patterns, ordered {auxn_sbu1, auxp_sbu2, auxn_sbu2, auxp_sbu1}
  localparam logic [3:0] SW_OPEN     = 4'h0;
  localparam logic [3:0] SW_STRAIGHT = 4'hc;
  localparam logic [3:0] SW_CROSSED  = 4'h3;
  // Snooped byte widths follow the register field widths
  localparam int         PWR_W       = PWR_HI - PWR_LO + 1;
  localparam int         CNT_W       = CNT_HI - CNT_LO + 1;

  logic [3:0]      cfg_lanes;
  logic [3:0]      count_lanes;
  logic [3:0]      snoop_lanes;
  logic [3:0]      lanes_wanted;
  logic            cfg_usb;
  logic            power_on;
  logic            aux_native_wr;
  logic            aux_hit_power;
  logic            aux_hit_count;
  logic            enable_fell;
  logic            eq_write;
  logic            route_write;
  logic [EQ_W-1:0] eq0_next;
  logic [EQ_W-1:0] eq2_next;
  logic [1:0]      power_next;
  logic [4:0]      count_next;
  logic [7:0]      read_word;
  logic [3:0]      sbu_route;

  // Strobe decodes are kept apart so each rule reads as one term
  always_comb begin
    // Only native writes to the two watched addresses are snooped
    aux_native_wr = aux_req_valid && (aux_req_cmd == AUX_NATIVE_WR);
    aux_hit_power = aux_native_wr && (aux_req_addr == DPCD_POWER_STATE);
    aux_hit_count = aux_native_wr && (aux_req_addr == DPCD_LANE_COUNT);
    // Compared against the registered level, which resets to zero,
    // so no false fall follows reset
    enable_fell   = st_r.enable_d && !display_enable_ctrl;
    eq_write      = reg_wr && (reg_addr == ADDR_EQ) && eq_source_select;
    route_write   = reg_wr && (reg_addr == ADDR_ROUTE);
    power_on      = (st_r.power_state == PWR_ON);
  end

  // Config mask: which receivers the lane setting leaves powered
  always_comb begin
    case (lane_config_select)
      CFG_ALL_OFF: begin
        cfg_lanes = LANES_NONE;
        cfg_usb   = 1'b0;
      end
      CFG_USB_ONLY: begin
        cfg_lanes = LANES_NONE;
        cfg_usb   = 1'b1;
      end
      CFG_DP_FOUR: begin
        cfg_lanes = LANES_ALL;
        cfg_usb   = 1'b0;
      end
      CFG_DP_TWO_USB: begin
        cfg_lanes = LANES_TWO;
        cfg_usb   = 1'b1;
      end
      default: begin
        cfg_lanes = LANES_NONE;
        cfg_usb   = 1'b0;
      end
    endcase
  end

  // Unknown counts power every lane down rather than guess
  always_comb begin
    case (st_r.lane_count)
      CNT_ONE: begin
        count_lanes = LANES_ONE;
      end
      CNT_TWO: begin
        count_lanes = LANES_TWO;
      end
      CNT_FOUR: begin
        count_lanes = LANES_ALL;
      end
      default: begin
        count_lanes = LANES_NONE;
      end
    endcase
  end

  always_comb begin
    if (power_on) begin
      snoop_lanes = count_lanes;
    end else begin
      snoop_lanes = LANES_NONE;
    end
  end

  // The stored disable bits only matter once snooping is off
  always_comb begin
    if (st_r.snoop_off) begin
      lanes_wanted = ~st_r.per_lane_off_bits;
    end else begin
      lanes_wanted = snoop_lanes;
    end
  end

  // Pins are mirrored into the fields while override is clear
  always_comb begin
    if (!eq_source_select) begin
      eq0_next = dp_eq_strap_pins;
      eq2_next = dp_eq_strap_pins;
    end else if (eq_write) begin
      eq0_next = reg_wdata[LANE0_EQ_HI:LANE0_EQ_LO];
      eq2_next = reg_wdata[LANE2_EQ_HI:LANE2_EQ_LO];
    end else begin
      eq0_next = st_r.lane0_eq_level;
      eq2_next = st_r.lane2_eq_level;
    end
  end

  // Snooped fields hold the last matching write until the display drops
  always_comb begin
    power_next = st_r.power_state;
    count_next = st_r.lane_count;
    if (aux_hit_power) begin
      power_next = aux_req_data[PWR_W-1:0];
    end
    if (aux_hit_count) begin
      count_next = aux_req_data[CNT_W-1:0];
    end
    // Disabling the display wins over a same-cycle snooped write
    if (enable_fell) begin
      power_next = PWR_CLEAR;
      count_next = CNT_CLEAR;
    end
  end

  // Read data path: reserved bits read as zero
  always_comb begin
    case (reg_addr)
      ADDR_EQ: begin
        read_word = {st_r.lane0_eq_level, st_r.lane2_eq_level};
      end
      ADDR_SNOOP: begin
        read_word = {1'b0, st_r.power_state, st_r.lane_count};
      end
      ADDR_ROUTE: begin
        read_word = {st_r.snoop_off, 1'b0,
                     st_r.sideband_route_override,
                     st_r.per_lane_off_bits};
      end
      default: begin
        read_word = RESERVED_RD;
      end
    endcase
  end

  // Route comes from the stored field, so a write shows one edge later
  always_comb begin
    case (st_r.sideband_route_override)
      SBU_AUTO: begin
        if (!display_enable_ctrl) begin
          sbu_route = SW_OPEN;
        end else if (orientation_select) begin
          sbu_route = SW_CROSSED;
        end else begin
          sbu_route = SW_STRAIGHT;
        end
      end
      SBU_N1_P2: begin
        sbu_route = SW_STRAIGHT;
      end
      SBU_N2_P1: begin
        sbu_route = SW_CROSSED;
      end
      SBU_OPEN: begin
        sbu_route = SW_OPEN;
      end
      default: begin
        sbu_route = SW_OPEN;
      end
    endcase
  end

  // Output stage mirrors the fields one edge later
  always_comb begin
    st_nxt                = st_r;
    st_nxt.enable_d       = display_enable_ctrl;
    st_nxt.lane0_eq_level = eq0_next;
    st_nxt.lane2_eq_level = eq2_next;
    st_nxt.power_state    = power_next;
    st_nxt.lane_count     = count_next;
    if (route_write) begin
      st_nxt.snoop_off               = reg_wdata[SNOOP_OFF_BIT];
      st_nxt.sideband_route_override = reg_wdata[ROUTE_HI:ROUTE_LO];
      st_nxt.per_lane_off_bits       = reg_wdata[OFF_HI:OFF_LO];
    end
    if (reg_rd) begin
      st_nxt.rdata = read_word;
    end else begin
      st_nxt.rdata = RESERVED_RD;
    end
    st_nxt.lane_en = lanes_wanted & cfg_lanes;
    st_nxt.usb_en  = cfg_usb;
    st_nxt.eq0     = st_r.lane0_eq_level;
    st_nxt.eq2     = st_r.lane2_eq_level;
    st_nxt.sbu     = sbu_route;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata        = st_r.rdata;
  assign dp_lane_en       = st_r.lane_en;
  assign usb3_en          = st_r.usb_en;
  assign lane0_eq_applied = st_r.eq0;
  assign lane2_eq_applied = st_r.eq2;
  assign auxn_sbu1        = st_r.sbu[3];
  assign auxp_sbu2        = st_r.sbu[2];
  assign auxn_sbu2        = st_r.sbu[1];
  assign auxp_sbu1        = st_r.sbu[0];

endmodule : dp_lane_aux_snoop_ctrl

// file: hdl/dp_lane_aux_snoop_pkg.sv
// Constants for the DP lane and AUX snoop control register bank.
// Assumes byte-wide register access at 8-bit addresses.
package dp_lane_aux_snoop_pkg;
  localparam logic [7:0] ADDR_EQ      = 8'h11;
  localparam logic [7:0] ADDR_SNOOP   = 8'h12;
  localparam logic [7:0] ADDR_ROUTE   = 8'h13;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] RESERVED_RD  = 8'h00;
  localparam int LANE0_EQ_HI    = 7;
  localparam int LANE0_EQ_LO    = 4;
  localparam int LANE2_EQ_HI    = 3;
  localparam int LANE2_EQ_LO    = 0;
  localparam int PWR_HI         = 6;
  localparam int PWR_LO         = 5;
  localparam int CNT_HI         = 4;
  localparam int CNT_LO         = 0;
  localparam int SNOOP_OFF_BIT  = 7;
  localparam int ROUTE_HI       = 5;
  localparam int ROUTE_LO       = 4;
  localparam int OFF_HI         = 3;
  localparam int OFF_LO         = 0;
  // DPCD addresses watched on the AUX link
  localparam logic [19:0] DPCD_POWER_STATE = 20'h0_0600;
  localparam logic [19:0] DPCD_LANE_COUNT  = 20'h0_0101;
  // AUX native write request command nibble
  localparam logic [3:0]  AUX_NATIVE_WR    = 4'h8;
  // Power state value meaning normal operation
  localparam logic [1:0]  PWR_ON           = 2'b01;
  localparam logic [1:0]  PWR_CLEAR        = 2'b00;
  localparam logic [4:0]  CNT_CLEAR        = 5'h00;
  localparam logic [4:0]  CNT_ONE          = 5'h01;
  localparam logic [4:0]  CNT_TWO          = 5'h02;
  localparam logic [4:0]  CNT_FOUR         = 5'h04;
  localparam logic [3:0]  LANES_NONE       = 4'h0;
  localparam logic [3:0]  LANES_ONE        = 4'h1;
  localparam logic [3:0]  LANES_TWO        = 4'h3;
  localparam logic [3:0]  LANES_ALL        = 4'hf;
  localparam logic [1:0]  CFG_ALL_OFF      = 2'b00;
  localparam logic [1:0]  CFG_USB_ONLY     = 2'b01;
  localparam logic [1:0]  CFG_DP_FOUR      = 2'b10;
  localparam logic [1:0]  CFG_DP_TWO_USB   = 2'b11;
  typedef enum logic [1:0] {
    SBU_AUTO     = 2'b00,
    SBU_N1_P2    = 2'b01,
    SBU_N2_P1    = 2'b10,
    SBU_OPEN     = 2'b11
  } sbu_route_e;
endpackage : dp_lane_aux_snoop_pkg

// file: testbench/aux_source_model.sv
// Far-side AUX source: one decoded request per send call.
// Assumes the bench calls send from its main sequence.
`timescale 1ns/1ps
module aux_source_model (
  input  wire logic   clk,
  output logic        aux_req_valid,
  output logic [3:0]  aux_req_cmd,
  output logic [19:0] aux_req_addr,
  output logic [7:0]  aux_req_data
);
  initial begin
    aux_req_valid = 1'b0;
    aux_req_cmd = 4'h0;
    aux_req_addr = 20'h0_0000;
    aux_req_data = 8'h00;
  end
  task automatic send(input logic [3:0] c, input logic [19:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    aux_req_valid <= 1'b1;
    aux_req_cmd <= c;
    aux_req_addr <= a;
    aux_req_data <= d;
    @(posedge clk);
    aux_req_valid <= 1'b0;
    // Stale address and data are inverted so a sticky decode cannot match
    aux_req_addr <= ~a;
    aux_req_data <= ~d;
  endtask : send
endmodule : aux_source_model

// file: testbench/dp_lane_aux_snoop_ctrl_chk.sv
// Port checker for the snoop control block.
// Assumes it is bound onto every instance of that block.
`timescale 1ns/1ps
module dp_lane_aux_snoop_chk #(
  parameter int EQ_W = 4
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_rdata,
  input wire logic            eq_source_select,
  input wire logic [EQ_W-1:0] dp_eq_strap_pins,
  input wire logic            display_enable_ctrl,
  input wire logic [1:0]      lane_config_select,
  input wire logic [3:0]      dp_lane_en,
  input wire logic [EQ_W-1:0] lane0_eq_applied,
  input wire logic [EQ_W-1:0] lane2_eq_applied,
  input wire logic            auxn_sbu1,
  input wire logic            auxp_sbu2,
  input wire logic            auxn_sbu2,
  input wire logic            auxp_sbu1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Three quiet cycles cover the pin sample plus output register
  a_eq0_pins: assert property (
    (!eq_source_select && $stable(dp_eq_strap_pins)) [*3]
    |-> lane0_eq_applied == dp_eq_strap_pins) else $error("lane0 eq");
  a_eq2_pins: assert property (
    (!eq_source_select && $stable(dp_eq_strap_pins)) [*3]
    |-> lane2_eq_applied == dp_eq_strap_pins) else $error("lane2 eq");
  a_fall_clear: assert property (
    $fell(display_enable_ctrl) ##1 (reg_rd && reg_addr == 8'h12)
    |=> reg_rdata == 8'h00) else $error("snoop not cleared");
  a_rsvd_zero: assert property (
    reg_rd && reg_addr == 8'h12 |=> !reg_rdata[7])
    else $error("reserved bit set");
  a_sbu_excl: assert property (
    !(auxn_sbu1 && auxn_sbu2) && !(auxp_sbu1 && auxp_sbu2))
    else $error("sbu short");
  a_sbu_pair: assert property (
    auxn_sbu1 == auxp_sbu2 && auxn_sbu2 == auxp_sbu1)
    else $error("sbu half route");
  a_cfg_off: assert property (
    !lane_config_select[1] [*3] |-> dp_lane_en == 4'h0)
    else $error("dp lanes on");
  a_cfg_two: assert property (
    (lane_config_select == 2'b11) [*3] |-> dp_lane_en[3:2] == 2'b00)
    else $error("upper lanes on");
endmodule : dp_lane_aux_snoop_chk

bind dp_lane_aux_snoop_ctrl dp_lane_aux_snoop_chk #(.EQ_W(EQ_W)) chk (
  .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .eq_source_select(eq_source_select),
  .dp_eq_strap_pins(dp_eq_strap_pins),
  .display_enable_ctrl(display_enable_ctrl),
  .lane_config_select(lane_config_select), .dp_lane_en(dp_lane_en),
  .lane0_eq_applied(lane0_eq_applied),
  .lane2_eq_applied(lane2_eq_applied), .auxn_sbu1(auxn_sbu1),
  .auxp_sbu2(auxp_sbu2), .auxn_sbu2(auxn_sbu2), .auxp_sbu1(auxp_sbu1));

// file: testbench/dp_lane_aux_snoop_ctrl_tb.sv
// Bench for the snoop control block: register calls and AUX requests.
// Assumes a 200 MHz clock and the aux_source_model far side.
`timescale 1ns/1ps
module dp_lane_aux_snoop_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic eq_sel = 1'b0, en = 1'b0, ori = 1'b0;
  logic [3:0] pins = 4'ha, lanes, l0, l2, v4, sbu_exp [4];
  logic [1:0] cfg = 2'b01;
  logic usb3, n1, p2, n2, p1, av;
  logic [19:0] aa;
  logic [7:0] ad, cfg_exp [4];
  int fails = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  aux_source_model src (.clk(clk), .aux_req_valid(av),
    .aux_req_cmd(v4), .aux_req_addr(aa), .aux_req_data(ad));
  dp_lane_aux_snoop_ctrl DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .eq_source_select(eq_sel),
    .dp_eq_strap_pins(pins), .display_enable_ctrl(en),
    .lane_config_select(cfg), .orientation_select(ori),
    .aux_req_valid(av), .aux_req_cmd(v4), .aux_req_addr(aa),
    .aux_req_data(ad), .dp_lane_en(lanes), .usb3_en(usb3),
    .lane0_eq_applied(l0), .lane2_eq_applied(l2), .auxn_sbu1(n1),
    .auxp_sbu2(p2), .auxn_sbu2(n2), .auxp_sbu1(p1));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  // Outputs are registered behind registers: allow three edges
  task automatic lane_is(input logic [7:0] e);
    repeat (3) @(posedge clk);
    #1 chk("lanes", {4'h0, lanes}, e);
  endtask : lane_is
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    report_and_stop;
  end
  initial begin
    sbu_exp = '{4'h0, 4'hc, 4'h3, 4'h0};
    cfg_exp = '{8'h00, 8'h10, 8'h0f, 8'h13};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h14, 8'h00);
    wr(8'h11, 8'h5c);
    rd(8'h11, 8'haa);
    @(posedge clk) eq_sel <= 1'b1;
    wr(8'h11, 8'h5c);
    rd(8'h11, 8'h5c);
    chk("eq", {l0, l2}, 8'h5c);
    @(posedge clk) en <= 1'b1;
    @(posedge clk) cfg <= 2'b10;
    src.send(4'h8, 20'h0_0600, 8'h01);
    src.send(4'h8, 20'h0_0101, 8'h02);
    rd(8'h12, 8'h22);
    lane_is(8'h03);
    wr(8'h12, 8'hff);
    src.send(4'h9, 20'h0_0101, 8'h04);
    src.send(4'h8, 20'h0_0102, 8'h04);
    rd(8'h12, 8'h22);
    src.send(4'h8, 20'h0_0101, 8'h04);
    wr(8'h13, 8'h0f);
    lane_is(8'h0f);
    rd(8'h13, 8'h0f);
    wr(8'h13, 8'h85);
    lane_is(8'h0a);
    wr(8'h13, 8'h00);
    src.send(4'h8, 20'h0_0600, 8'h02);
    lane_is(8'h00);
    @(posedge clk) en <= 1'b0;
    rd(8'h12, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(8'h13, {2'b00, 2'(r), 4'h0});
      lane_is(8'h00);
      chk("sbu", {n1, p2, n2, p1}, sbu_exp[r]);
    end
    wr(8'h13, 8'h80);
    @(posedge clk) en <= 1'b1;
    lane_is(8'h0f);
    chk("sbu", {n1, p2, n2, p1}, 4'hc);
    @(posedge clk) ori <= 1'b1;
    lane_is(8'h0f);
    chk("sbu", {n1, p2, n2, p1}, 4'h3);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk) cfg <= 2'(c);
      lane_is(cfg_exp[c] & 8'h0f);
      chk("usb3", {7'h00, usb3}, {7'h00, cfg_exp[c][4]});
    end
    report_and_stop;
  end
endmodule : dp_lane_aux_snoop_ctrl_tb
